//--- verilog/aimp_pkg.sv
package aimp_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ      = 25000000;
  localparam int AUX_SCL_HZ  = 400000;
  // Quarter bit period, rounded up
  localparam int AUX_QTR_CYC = (CLK_HZ + 4 * AUX_SCL_HZ - 1) / (4 * AUX_SCL_HZ);
  localparam logic [4:0] AUX_QTR_LAST = 5'(AUX_QTR_CYC - 1);
  // Pass-through direction settle time
  localparam logic [2:0] PASS_GUARD = 3'h4;

  // ----------------------------------------
  // Addresses and fields
  // ----------------------------------------
  localparam logic [5:0] OWN_ADDR_HI = 6'h34;
  localparam logic       I2C_RD      = 1'b1;
  localparam logic       I2C_WR      = 1'b0;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_FIRST   = 4'h0;
  localparam logic [7:0] AXIS_BYTES  = 8'h06;
  localparam logic [2:0] LAST_BYTE   = 3'h5;
  localparam logic [7:0] DATA_NONE   = 8'h00;

  // ----------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------
  localparam int SYNC_W = 6;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_AUX = 2;
  localparam int SY_DRV = 3;
  localparam int SY_WR  = 4;
  localparam int SY_RD  = 5;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_START = 2'h0, CMD_WRITE = 2'h1, CMD_READ = 2'h2, CMD_STOP = 2'h3
  } aimp_cmd_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_START = 3'h1, M_ADDRW = 3'h2, M_REG = 3'h3,
    M_RSTART = 3'h4, M_ADDRR = 3'h5, M_READ = 3'h6, M_STOP = 3'h7
  } aimp_mst_t;

  typedef enum logic [1:0] {
    PASS_IDLE = 2'h0, PASS_HOST = 2'h1, PASS_AUX = 2'h2
  } aimp_own_t;
endpackage

//--- verilog/aimp_aux_engine.sv
`timescale 1ns/1ps
module aimp_aux_engine
  import aimp_pkg::*;
(
  input  wire logic       mclk,      // System clock
  input  wire logic       reset,     // Async reset
  input  wire logic       go,        // Start one command
  input  wire aimp_cmd_t  cmd,       // Command
  input  wire logic [7:0] wr_byte,   // Byte to send
  input  wire logic       nack_last, // Read: answer not-ack
  input  wire logic       sda_in,    // Synced aux data
  output logic            done,      // Command finished
  output logic [7:0]      rd_byte,   // Byte received
  output logic            nack_seen, // Write got no ack
  output logic            scl_out,   // Aux clock level
  output logic            sda_oe     // Pull aux data low
);
  import aimp_pkg::*;

  logic       busy_ff;
  aimp_cmd_t  cmd_ff;
  logic [4:0] qcnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic       nack_ff;
  logic       tick;

  assign tick = busy_ff && (qcnt_ff == AUX_QTR_LAST);

  // Pull-low flag for one bit slot
  function automatic logic drive_for(input aimp_cmd_t c, input logic [3:0] b,
                                     input logic [7:0] s, input logic nl);
    if (b == BIT_ACK)
      drive_for = (c == CMD_READ) && !nl;
    else
      drive_for = (c == CMD_WRITE) && !s[7];
  endfunction

  // ----------------------------------------
  // Quarter-period timing
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      qcnt_ff <= '0;
    else if (go || tick)
      qcnt_ff <= '0;
    else if (busy_ff)
      qcnt_ff <= qcnt_ff + 5'h1;
  end

  // ----------------------------------------
  // Bit sequencing and pin levels
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_ff   <= 1'b0;
      cmd_ff    <= CMD_STOP;
      phase_ff  <= '0;
      bit_ff    <= '0;
      sh_ff     <= '0;
      nack_ff   <= 1'b0;
      done      <= 1'b0;
      rd_byte   <= '0;
      nack_seen <= 1'b0;
      scl_out   <= 1'b1;
      sda_oe    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go) begin
        busy_ff  <= 1'b1;
        cmd_ff   <= cmd;
        phase_ff <= '0;
        bit_ff   <= BIT_FIRST;
        sh_ff    <= wr_byte;
        nack_ff  <= nack_last;
        scl_out  <= 1'b0;
        // Stop pulls data low; bytes set bit one
        sda_oe   <= (cmd == CMD_STOP) || drive_for(cmd, BIT_FIRST, wr_byte, nack_last);
      end else if (tick) begin
        phase_ff <= phase_ff + 2'h1;
        unique case (phase_ff)
          2'h0: scl_out <= 1'b1;
          2'h1: begin
            if (cmd_ff == CMD_START)
              sda_oe <= 1'b1;
            else if (cmd_ff == CMD_STOP)
              sda_oe <= 1'b0;
            else if (bit_ff == BIT_ACK)
              nack_seen <= sda_in;
            else
              rd_byte <= {rd_byte[6:0], sda_in};
          end
          2'h2: if (cmd_ff != CMD_STOP) scl_out <= 1'b0;
          2'h3: begin
            if ((cmd_ff == CMD_WRITE || cmd_ff == CMD_READ) && bit_ff != BIT_ACK) begin
              bit_ff <= bit_ff + 4'h1;
              sh_ff  <= {sh_ff[6:0], 1'b0};
              sda_oe <= drive_for(cmd_ff, bit_ff + 4'h1, {sh_ff[6:0], 1'b0}, nack_ff);
            end else begin
              busy_ff <= 1'b0;
              done    <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule

//--- verilog/aimp_top.sv
`timescale 1ns/1ps
// What this block does
// - The aux bus runs either as the block's own master or as a pass-through of the host bus.
// - As master the block reads the accelerometer data on its own, without host traffic.
// - The master burst read returns X, Y and Z, two bytes each, in that order.
// - In pass-through the aux controller is idle, save a burst whose sample tick meets the switch, and the aux pins join the host bus.
// - In pass-through the block still answers the host as a slave on the host bus.
// - On the host bus the block is slave only and never starts a transfer.
// - The low bit of the slave address is the level on the address select pin.
// - As master the aux clock pin is push-pull, driven high and low.
// - As master the aux data pin is only pulled low, high comes from a pull-up.
// - Pass-through buffers host clock to aux clock and carries data both ways.
// - A setting chooses whether aux levels follow the main or the I/O supply.
// - The slave address is seven bits, six fixed high bits and the select bit.
// - As master, a missing accelerometer ack raises an event.
module aimp_top
  import aimp_pkg::*;
(
  input  wire logic       mclk,               // System clock
  input  wire logic       reset,              // Async reset, high
  input  wire logic       host_scl,           // Host bus clock, link clock
  input  wire logic       host_sda_in,        // Host data level
  output logic            host_sda_out,       // Host data drive value
  output logic            host_sda_oe,        // Pull host data low
  input  wire logic       address_select_pin, // Address low bit strap
  output logic            aux_clock_pin,      // Aux clock level
  output logic            aux_clock_oe,       // Aux clock drive
  input  wire logic       aux_data_in,        // Aux data level
  output logic            aux_data_out,       // Aux data drive value
  output logic            aux_data_oe,        // Pull aux data low
  input  wire logic       mode_passthrough,   // 1: pass-through
  input  wire logic       io_level_sel,       // 1: aux on I/O supply
  output logic            io_supply_level,    // Aux level select
  input  wire logic [6:0] accel_addr,         // Accelerometer address
  input  wire logic [7:0] accel_start_reg,    // First data register
  input  wire logic       sample_tick,        // Start a burst
  output logic            accel_valid,        // Burst complete
  output logic            aux_nack_event,     // No ack from accel
  output logic            host_wr_valid,      // Host wrote a register
  output logic [7:0]      host_wr_addr,       // Its address
  output logic [7:0]      host_wr_data        // Its data
);
  import aimp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [SYNC_W-1:0] sy1_ff;
  logic [SYNC_W-1:0] sy2_ff;
  logic [1:0]        tg3_ff;
  logic              sda_prev_ff;
  logic              lk_rst_ff;
  logic              scl_s;
  logic              sda_s;
  logic              aux_s;
  logic              wr_evt;
  logic              rd_evt;
  logic              mode_pass_ff;
  // Link domain
  logic [3:0]        lk_bit_ff;
  logic [7:0]        lk_rx_ff;
  logic              lk_acked_ff;
  logic              lk_sel1_ff;
  logic              lk_sel2_ff;
  logic              lk_addr_ff;
  logic              lk_rw_ff;
  logic              lk_first_ff;
  logic              lk_drv_ff;
  logic [7:0]        lk_sh_ff;
  logic [7:0]        lk_wr_byte_ff;
  logic              lk_wr_ptr_ff;
  logic              lk_wr_tgl_ff;
  logic              lk_rd_tgl_ff;
  // Register access
  logic [7:0]        ptr_ff;
  logic [7:0]        tx_ff;
  logic [7:0]        bank_ff [0:5];
  // Pass-through
  aimp_own_t         own_ff;
  logic [2:0]        guard_ff;
  // Aux master
  aimp_mst_t         mst_ff;
  logic              issued_ff;
  logic [2:0]        bidx_ff;
  logic              eng_go_ff;
  aimp_cmd_t         eng_cmd;
  logic [7:0]        eng_byte;
  logic              eng_nl;
  logic              eng_done;
  logic [7:0]        eng_rd;
  logic              eng_nack;
  logic              eng_scl;
  logic              eng_sda_oe;

  // ----------------------------------------
  // Synchronisers into the system clock
  // ----------------------------------------
  // Pins and link-domain levels, two flops each
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sy1_ff <= {3'h0, 3'h7};
      sy2_ff <= {3'h0, 3'h7};
    end else begin
      sy1_ff <= {lk_rd_tgl_ff, lk_wr_tgl_ff, lk_drv_ff, aux_data_in, host_sda_in, host_scl};
      sy2_ff <= sy1_ff;
    end
  end

  // Third stage for toggle edge detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tg3_ff      <= '0;
      sda_prev_ff <= 1'b1;
    end else begin
      tg3_ff      <= {sy2_ff[SY_RD], sy2_ff[SY_WR]};
      sda_prev_ff <= sda_s;
    end
  end

  assign scl_s  = sy2_ff[SY_SCL];
  assign sda_s  = sy2_ff[SY_SDA];
  assign aux_s  = sy2_ff[SY_AUX];
  assign wr_evt = sy2_ff[SY_WR] ^ tg3_ff[0];
  assign rd_evt = sy2_ff[SY_RD] ^ tg3_ff[1];

  // Start or stop clears the link logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      lk_rst_ff <= 1'b1;
    else
      lk_rst_ff <= scl_s && (sda_prev_ff != sda_s);
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  // Switch only while the master is idle, so no running burst is cut; one begun in the switch cycle runs on pass-through pins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      mode_pass_ff <= 1'b0;
    else if (mst_ff == M_IDLE && !eng_go_ff)
      mode_pass_ff <= mode_passthrough;
  end

  // ----------------------------------------
  // Host slave, link clock domain
  // ----------------------------------------
  // Strap level caught on the link clock
  always_ff @(posedge host_scl or posedge reset) begin
    if (reset) begin
      lk_sel1_ff <= 1'b0;
      lk_sel2_ff <= 1'b0;
    end else begin
      lk_sel1_ff <= address_select_pin;
      lk_sel2_ff <= lk_sel1_ff;
    end
  end

  // Bit count and receive shift on rising clock
  always_ff @(posedge host_scl or posedge lk_rst_ff) begin
    if (lk_rst_ff) begin
      lk_bit_ff   <= BIT_FIRST;
      lk_rx_ff    <= '0;
      lk_acked_ff <= 1'b0;
    end else if (lk_bit_ff == BIT_ACK) begin
      lk_bit_ff   <= BIT_FIRST;
      lk_acked_ff <= !host_sda_in;
    end else begin
      lk_bit_ff <= lk_bit_ff + 4'h1;
      lk_rx_ff  <= {lk_rx_ff[6:0], host_sda_in};
    end
  end

  // Address match, ack and read data on falling clock
  always_ff @(negedge host_scl or posedge lk_rst_ff) begin
    if (lk_rst_ff) begin
      lk_addr_ff  <= 1'b0;
      lk_rw_ff    <= I2C_WR;
      lk_first_ff <= 1'b0;
      lk_drv_ff   <= 1'b0;
      lk_sh_ff    <= '0;
    end else begin
      lk_drv_ff <= 1'b0;
      if (lk_bit_ff == BIT_ACK) begin
        if (!lk_addr_ff) begin
          if (lk_rx_ff[7:1] == {OWN_ADDR_HI, lk_sel2_ff}) begin
            lk_addr_ff  <= 1'b1;
            lk_rw_ff    <= lk_rx_ff[0];
            lk_first_ff <= (lk_rx_ff[0] == I2C_WR);
            lk_drv_ff   <= 1'b1;
          end
        end else if (lk_rw_ff == I2C_WR) begin
          lk_first_ff <= 1'b0;
          lk_drv_ff   <= 1'b1;
        end
      end else if (lk_addr_ff && lk_rw_ff == I2C_RD && lk_acked_ff) begin
        // Host nack stops the data; the slave never drives the clock
        if (lk_bit_ff == BIT_FIRST) begin
          lk_drv_ff <= !tx_ff[7];
          lk_sh_ff  <= {tx_ff[6:0], 1'b0};
        end else begin
          lk_drv_ff <= !lk_sh_ff[7];
          lk_sh_ff  <= {lk_sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Byte hand-over toggles; data stays put until the next toggle
  always_ff @(negedge host_scl or posedge reset) begin
    if (reset) begin
      lk_wr_byte_ff <= '0;
      lk_wr_ptr_ff  <= 1'b0;
      lk_wr_tgl_ff  <= 1'b0;
      lk_rd_tgl_ff  <= 1'b0;
    end else begin
      if (lk_bit_ff == BIT_ACK && lk_addr_ff && lk_rw_ff == I2C_WR) begin
        lk_wr_byte_ff <= lk_rx_ff;
        lk_wr_ptr_ff  <= lk_first_ff;
        lk_wr_tgl_ff  <= !lk_wr_tgl_ff;
      end
      if (lk_bit_ff == BIT_FIRST && lk_addr_ff && lk_rw_ff == I2C_RD && lk_acked_ff)
        lk_rd_tgl_ff <= !lk_rd_tgl_ff;
    end
  end

  // ----------------------------------------
  // Register access, system clock
  // ----------------------------------------
  // Pointer and write strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ptr_ff        <= '0;
      host_wr_valid <= 1'b0;
      host_wr_addr  <= '0;
      host_wr_data  <= '0;
    end else begin
      host_wr_valid <= 1'b0;
      if (wr_evt) begin
        if (lk_wr_ptr_ff) begin
          ptr_ff <= lk_wr_byte_ff;
        end else begin
          host_wr_valid <= 1'b1;
          host_wr_addr  <= ptr_ff;
          host_wr_data  <= lk_wr_byte_ff;
          ptr_ff        <= ptr_ff + 8'h01;
        end
      end else if (rd_evt) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end
  end

  // Read byte ready for the link side
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      tx_ff <= DATA_NONE;
    else if (ptr_ff < AXIS_BYTES)
      tx_ff <= bank_ff[ptr_ff[2:0]];
    else
      tx_ff <= DATA_NONE;
  end

  // ----------------------------------------
  // Pass-through data direction
  // ----------------------------------------
  // First side to pull low owns the line; guard lets echoes settle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      own_ff   <= PASS_IDLE;
      guard_ff <= '0;
    end else if (!mode_pass_ff) begin
      own_ff   <= PASS_IDLE;
      guard_ff <= '0;
    end else begin
      unique case (own_ff)
        PASS_IDLE: begin
          if (guard_ff != 3'h0)
            guard_ff <= guard_ff - 3'h1;
          else if (!sda_s && !sy2_ff[SY_DRV])
            own_ff <= PASS_HOST;
          else if (!aux_s)
            own_ff <= PASS_AUX;
        end
        PASS_HOST: if (sda_s) begin
          own_ff   <= PASS_IDLE;
          guard_ff <= PASS_GUARD;
        end
        PASS_AUX: if (aux_s) begin
          own_ff   <= PASS_IDLE;
          guard_ff <= PASS_GUARD;
        end
        default: own_ff <= PASS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Aux master sequencer
  // ----------------------------------------
  // Command and byte per burst step
  always_comb begin
    eng_cmd  = CMD_WRITE;
    eng_byte = {accel_addr, I2C_WR};
    eng_nl   = 1'b0;
    unique case (mst_ff)
      M_START, M_RSTART: eng_cmd = CMD_START;
      M_REG:   eng_byte = accel_start_reg;
      M_ADDRR: eng_byte = {accel_addr, I2C_RD};
      M_READ: begin
        eng_cmd = CMD_READ;
        eng_nl  = (bidx_ff == LAST_BYTE);
      end
      M_STOP:  eng_cmd = CMD_STOP;
      M_IDLE, M_ADDRW: eng_cmd = CMD_WRITE;
    endcase
  end

  // Burst state machine, no host traffic needed
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mst_ff    <= M_IDLE;
      issued_ff <= 1'b0;
      bidx_ff   <= '0;
      eng_go_ff <= 1'b0;
    end else begin
      eng_go_ff <= 1'b0;
      if (mst_ff == M_IDLE) begin
        issued_ff <= 1'b0;
        bidx_ff   <= '0;
        if (!mode_pass_ff && sample_tick)
          mst_ff <= M_START;
      end else if (!issued_ff) begin
        issued_ff <= 1'b1;
        eng_go_ff <= 1'b1;
      end else if (eng_done) begin
        issued_ff <= 1'b0;
        unique case (mst_ff)
          M_START:  mst_ff <= M_ADDRW;
          M_ADDRW:  mst_ff <= eng_nack ? M_STOP : M_REG;
          M_REG:    mst_ff <= eng_nack ? M_STOP : M_RSTART;
          M_RSTART: mst_ff <= M_ADDRR;
          M_ADDRR:  mst_ff <= eng_nack ? M_STOP : M_READ;
          M_READ: begin
            bidx_ff <= bidx_ff + 3'h1;
            if (bidx_ff == LAST_BYTE)
              mst_ff <= M_STOP;
          end
          M_STOP:   mst_ff <= M_IDLE;
          M_IDLE:   mst_ff <= M_IDLE;
        endcase
      end
    end
  end

  // Sample bank, X, Y, Z as received
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 6; i++)
        bank_ff[i] <= DATA_NONE;
    end else if (mst_ff == M_READ && issued_ff && eng_done) begin
      bank_ff[bidx_ff] <= eng_rd;
    end
  end

  // Burst complete and missing-ack events
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accel_valid    <= 1'b0;
      aux_nack_event <= 1'b0;
    end else begin
      accel_valid    <= (mst_ff == M_READ) && issued_ff && eng_done && (bidx_ff == LAST_BYTE);
      aux_nack_event <= issued_ff && eng_done && eng_nack &&
                        (mst_ff == M_ADDRW || mst_ff == M_REG || mst_ff == M_ADDRR);
    end
  end

  aimp_aux_engine u_engine (
    .mclk      (mclk),
    .reset     (reset),
    .go        (eng_go_ff),
    .cmd       (eng_cmd),
    .wr_byte   (eng_byte),
    .nack_last (eng_nl),
    .sda_in    (aux_s),
    .done      (eng_done),
    .rd_byte   (eng_rd),
    .nack_seen (eng_nack),
    .scl_out   (eng_scl),
    .sda_oe    (eng_sda_oe)
  );

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Open-drain lines drive zero only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_sda_out <= 1'b0;
      aux_data_out <= 1'b0;
    end else begin
      host_sda_out <= 1'b0;
      aux_data_out <= 1'b0;
    end
  end

  // Host data: own slave answer or aux side in pass-through
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      host_sda_oe <= 1'b0;
    else
      host_sda_oe <= sy2_ff[SY_DRV] || (mode_pass_ff && own_ff == PASS_AUX);
  end

  // Aux clock always driven
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aux_clock_pin <= 1'b1;
      aux_clock_oe  <= 1'b1;
    end else begin
      aux_clock_oe  <= 1'b1;
      aux_clock_pin <= mode_pass_ff ? scl_s : eng_scl;
    end
  end

  // Aux data: pulled low only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      aux_data_oe <= 1'b0;
    else if (mode_pass_ff)
      aux_data_oe <= (own_ff == PASS_HOST);
    else
      aux_data_oe <= eng_sda_oe;
  end

  // Supply choice for aux pad levels
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      io_supply_level <= 1'b0;
    else
      io_supply_level <= io_level_sel;
  end
endmodule

//--- verification/aimp_top_assertions.sv
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module aimp_top_assertions (
  input wire logic       mclk,             // Clock
  input wire logic       reset,            // Reset
  input wire logic       host_scl,         // Host clock
  input wire logic       host_sda_in,      // Host data
  input wire logic       host_sda_out,     // Host drive value
  input wire logic       host_sda_oe,      // Host pull low
  input wire logic       aux_clock_pin,    // Aux clock
  input wire logic       aux_clock_oe,     // Aux clock drive
  input wire logic       aux_data_out,     // Aux drive value
  input wire logic       aux_data_oe,      // Aux pull low
  input wire logic       mode_passthrough, // Mode
  input wire logic       io_level_sel,     // Level setting
  input wire logic       io_supply_level,  // Level out
  input wire logic       accel_valid,      // Burst done
  input wire logic       aux_nack_event,   // Accel nack
  input wire logic       host_wr_valid,    // Host write
  input wire logic [7:0] host_wr_data      // Host write data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Pin drive style
  AST_CLK_OE: assert property (aux_clock_oe)
    else $error("aux clock not driven");
  AST_OPEN_DRAIN: assert property (!aux_data_out && !host_sda_out)
    else $error("data line driven high");
  AST_LEVEL: assert property (!$past(reset) |-> io_supply_level == $past(io_level_sel))
    else $error("level not followed");
  // Pass-through; 8-cycle windows cover sync lag
  AST_PASS_CLK: assert property (mode_passthrough [*8] |-> aux_clock_pin == $past(host_scl, 3))
    else $error("aux clock off host");
  AST_PASS_IDLE: assert property ((mode_passthrough && host_sda_in) [*8] |-> !aux_data_oe)
    else $error("aux pulled, host idle");
  AST_PASS_FWD: assert property ((mode_passthrough && !host_sda_in && !host_sda_oe) [*8] |-> aux_data_oe)
    else $error("host low not forwarded");
  // Slave drives only with clock low
  AST_HOST_EDGE: assert property ($changed(host_sda_oe) |-> !host_scl)
    else $error("host data moved, clock high");
  AST_VALID_PULSE: assert property (accel_valid |=> !accel_valid)
    else $error("burst done not a pulse");
  AST_NACK_PULSE: assert property (aux_nack_event |=> !aux_nack_event)
    else $error("nack event not a pulse");
  AST_WR_HOLD: assert property (!host_wr_valid |-> $stable(host_wr_data))
    else $error("write data moved");
  COV_BURST: cover property (accel_valid);
  COV_NACK: cover property (aux_nack_event);
  COV_PASS_WR: cover property (mode_passthrough && host_wr_valid);
endmodule

//--- verification/aimp_accel_model.sv
`timescale 1ns/1ps
// ----------
// Accelerometer on the aux bus
// ----------
module aimp_accel_model #(
  parameter logic [6:0] ADDR = 7'h1d  // Arbitrary address
) (
  input  wire logic scl,      // Aux clock
  input  wire logic sda,      // Resolved aux data
  input  wire logic nack_all, // Refuse all addresses
  output logic      sda_oe    // Pull data low
);
  logic [7:0] sh, dq, ptr;
  logic       act, rd, ok, mack;
  int         n, b;
  initial {sda_oe, act, ptr} = '0;
  // Start or repeated start
  always @(negedge sda) begin
    if (scl) begin
      {act, rd, ok, mack} = 4'h9;
      n = -1;
      b = 0;
    end
  end
  // Stop frees the bus
  always @(posedge sda) begin
    if (scl) act = 1'h0;
  end
  // Sample bits and master ack
  always @(posedge scl) begin
    if (act && n < 8) sh = {sh[6:0], sda};
    else if (act && rd) mack = !sda;
  end
  // Drive with clock low: no false start or stop
  always @(negedge scl) begin
    if (act) begin
      n++;
      sda_oe = 1'h0;
      if (n == 8 && !rd) begin
        if (b == 0) {ok, rd} = {sh[7:1] == ADDR && !nack_all, sh[0]};
        else if (b == 1 && ok) ptr = sh;
        sda_oe = ok;
      end
      if (n == 9) begin
        n = 0;
        b++;
        dq = ~ptr;
        if (rd) ptr++;
      end
      if (rd && ok && mack && n < 8) sda_oe = !dq[7 - n];
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; \
  if ((a) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  import aimp_pkg::*;
  localparam int         H   = 20;    // Link clocks per half bit
  localparam logic [6:0] ACC = 7'h1d; // Accel address
  logic       mclk, lclk, reset, host_scl, hd_low, address_select_pin;
  logic       mode_passthrough, io_level_sel, sample_tick, nack_all, acc_oe;
  logic       host_sda_oe, aux_clock_pin, aux_clock_oe, aux_data_oe;
  logic       io_supply_level, accel_valid, aux_nack_event, a;
  logic [7:0] host_wr_addr, host_wr_data, r;
  int         err_count, compares, k;
  // Rows: strap/level, address, ack
  logic [8:0] rows [4] = '{{1'h1, 7'h69, 1'h1}, {1'h1, 7'h68, 1'h0}, {1'h0, 7'h68, 1'h1}, {1'h0, 7'h69, 1'h0}};
  wire        host_sda_in = !(hd_low || host_sda_oe);
  wire        aux_data_in = !(aux_data_oe || acc_oe);
  always #20 mclk = ~mclk;
  always #32 lclk = ~lclk;
  aimp_top DUT (.mclk, .reset, .host_scl, .host_sda_in, .host_sda_out(), .host_sda_oe, .address_select_pin,
    .aux_clock_pin, .aux_clock_oe, .aux_data_in, .aux_data_out(), .aux_data_oe, .mode_passthrough,
    .io_level_sel, .io_supply_level, .accel_addr(ACC), .accel_start_reg(8'h32), .sample_tick, .accel_valid,
    .aux_nack_event, .host_wr_valid(), .host_wr_addr, .host_wr_data);
  aimp_accel_model #(.ADDR(ACC)) u_acc (.scl(aux_clock_pin), .sda(aux_data_in), .nack_all, .sda_oe(acc_oe));
  // ----------
  // Host bus tasks, paced by the link clock
  // ----------
  task automatic hbit(input logic v, output logic s);
    @(posedge lclk) hd_low <= !v;
    repeat (H) @(posedge lclk);
    host_scl <= 1'h1;
    repeat (H) @(posedge lclk);
    s = host_sda_in;
    host_scl <= 1'h0;
  endtask
  task automatic hbyte(input logic [7:0] b, input logic m, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      hbit(b[i], s);
      q[i] = s;
    end
    hbit(m, s);
    ack = !s;
  endtask
  // Start if st, else stop
  task automatic hcond(input logic st);
    @(posedge lclk) hd_low <= !st;
    repeat (H) @(posedge lclk);
    host_scl <= 1'h1;
    repeat (H) @(posedge lclk);
    hd_low <= st;
    repeat (H) @(posedge lclk);
    if (st) host_scl <= 1'h0;
  endtask
  // Burst, wait for done or nack
  task automatic burst(input logic s);
    @(posedge mclk) sample_tick <= 1'h1;
    @(posedge mclk) sample_tick <= 1'h0;
    for (k = 0; k < 9000 && (s ? aux_nack_event : accel_valid) !== 1'h1; k++) @(negedge mclk);
    `CHK("burst", 1'h1, s ? aux_nack_event : accel_valid)
  endtask
  task automatic end_of_test;
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    {mclk, lclk, hd_low, address_select_pin, mode_passthrough, io_level_sel, sample_tick, nack_all} = '0;
    {reset, host_scl} = 2'h3;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("rst_pins", 4'hc, {aux_clock_pin, aux_clock_oe, host_sda_oe, aux_data_oe})
    @(posedge mclk) reset <= 1'h0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) {address_select_pin, io_level_sel} <= {2{rows[i][8]}};
      hcond(1'h1);
      hbyte({rows[i][7:1], 1'h0}, 1'h1, r, a);
      hcond(1'h0);
      `CHK("addr_ack", rows[i][0], a)
      `CHK("io_level", rows[i][8], io_supply_level)
    end
    // Burst, then read the bank back
    burst(1'h0);
    hcond(1'h1);
    hbyte(8'hd0, 1'h1, r, a);
    hbyte(8'h00, 1'h1, r, a);
    hcond(1'h1);
    hbyte(8'hd1, 1'h1, r, a);
    for (int i = 0; i < 6; i++) begin
      hbyte(8'hff, i == 5, r, a);
      `CHK("axis_byte", ~(8'h32 + 8'(i)), r)
    end
    hcond(1'h0);
    @(posedge mclk) nack_all <= 1'h1;
    burst(1'h1);
    @(posedge mclk) nack_all <= 1'h0;
    // Let the stop finish
    repeat (100) @(posedge mclk);
    @(posedge mclk) mode_passthrough <= 1'h1;
    @(posedge mclk) sample_tick <= 1'h1;
    @(posedge mclk) sample_tick <= 1'h0;
    hcond(1'h1);
    hbyte({ACC, 1'h0}, 1'h1, r, a);
    hcond(1'h0);
    `CHK("pass_ack", 1'h1, a)
    hcond(1'h1);
    hbyte(8'hd0, 1'h1, r, a);
    hbyte(8'h03, 1'h1, r, a);
    hbyte(8'h10, 1'h1, r, a);
    hcond(1'h0);
    `CHK("own_ack", 1'h1, a)
    `CHK("own_wr", 16'h0310, {host_wr_addr, host_wr_data})
    end_of_test;
  end
  // Watchdog
  initial begin
    #3000000;
    err_count++;
    end_of_test;
  end
endmodule
bind aimp_top aimp_top_assertions u_chk (.mclk, .reset, .host_scl, .host_sda_in, .host_sda_out, .host_sda_oe,
  .aux_clock_pin, .aux_clock_oe, .aux_data_out, .aux_data_oe, .mode_passthrough, .io_level_sel,
  .io_supply_level, .accel_valid, .aux_nack_event, .host_wr_valid, .host_wr_data);
